// ### hdl/adc_sar_step.v
// one successive-approximation conversion: sample window then eight bit trials
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_sar_step #(
  parameter WIDTH = 8                       // result width
) (
  input  wire             clk_i,            // clock
  input  wire             arst_n_i,         // async reset, active low
  input  wire             start_i,          // begin a conversion
  input  wire             abort_i,          // drop conversion in progress
  input  wire             cmp_i,            // comparator: input above trial
  output reg              sample_o,         // sampling switch closed
  output reg  [WIDTH-1:0] trial_o,          // dac trial code
  output reg              done_o,           // pulse: result valid
  output reg  [WIDTH-1:0] result_o          // last result
);

  // ------------------------------------------------------------
  // sample counter and bit walk
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_SAMP = 2'd1;
  localparam ST_BITS = 2'd2;

  reg [1:0]       state_r;
  reg [4:0]       cnt_r;
  reg [WIDTH-1:0] mask_r;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r  <= ST_IDLE;
      cnt_r    <= 5'h00;
      mask_r   <= {WIDTH{1'b0}};
      sample_o <= 1'b0;
      trial_o  <= {WIDTH{1'b0}};
      done_o   <= 1'b0;
      result_o <= {WIDTH{1'b0}};
    end
    else
    begin
      done_o <= 1'b0;
      if (abort_i)
      begin
        state_r  <= ST_IDLE;
        sample_o <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            if (start_i)
            begin
              state_r  <= ST_SAMP;
              cnt_r    <= 5'h00;
              sample_o <= 1'b1;
            end
          end
          ST_SAMP:
          begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `SAMPLE_CYCLES_M1)
            begin
              sample_o <= 1'b0;
              state_r  <= ST_BITS;
              mask_r   <= {1'b1, {(WIDTH-1){1'b0}}};
              trial_o  <= {1'b1, {(WIDTH-1){1'b0}}};
            end
          end
          ST_BITS:
          begin
            // msb first; keep bit when input exceeds trial
            if (mask_r[0])
            begin
              result_o <= cmp_i ? trial_o : (trial_o & ~mask_r);
              done_o   <= 1'b1;
              state_r  <= ST_IDLE;
            end
            else
            begin
              trial_o <= (cmp_i ? trial_o : (trial_o & ~mask_r)) | (mask_r >> 1);
              mask_r  <= mask_r >> 1;
            end
          end
          default:
          begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // adc_sar_step
`default_nettype wire

// ### hdl/adc_seq_consts.vh
// register map, field positions and timing counts of the converter sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

`define ADC_CTL_ADDR        16'h1030
`define ADC_RES1_ADDR       16'h1031
`define ADC_RES2_ADDR       16'h1032
`define ADC_RES3_ADDR       16'h1033
`define ADC_RES4_ADDR       16'h1034
`define ADC_OPT_ADDR        16'h1039

`define CTL_CCF_BIT         7
`define CTL_RSVD_BIT        6
`define CTL_SCAN_BIT        5
`define CTL_GROUP_CHANNEL_MODE_BIT        4
`define OPT_CLOCK_SOURCE_SELECT_BIT        6

`define CTL_RESET           6'h00
`define OPT_RESET           1'b0

`define SAMPLE_CYCLES       5'd12
`define SAMPLE_CYCLES_M1    5'd11
`define CONV_CYCLES         6'd32
`define FIRST_RESULT_CYCLES 6'd34
`define SYNC_CYCLES         3'd4

`define CHAN_VH             4'hc
`define CHAN_VL             4'hd
`define CHAN_HALF           4'he

`endif

// ### hdl/adc_sequence_control.v
// converter sequencer with control/status and result registers on classic wishbone
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

// How it works
// - completion flag in bit 7 sets once all four results of the sequence are in.
// - any control write clears the flag and restarts a four-conversion sequence.
// - continuous mode keeps converting, overwriting results while the flag stays set.
// - bit 6 ignores writes and always reads zero.
// - scan bit clear gives exactly four conversions, then stop.
// - scan bit set cycles conversions forever, round robin.
// - group bit clear converts the one selected channel four times.
// - group bit set converts the four channels picked by upper two select bits.
// - group mode ignores low select bits; result slot follows channel low two bits.
// - codes 0-7 pins, 12 high ref, 13 low ref, 14 half ref, others reserved.
// - half reference is made by capacitor control during sampling, no divider.
// - result registers are read-only 8-bit values; writes do nothing.
// - results load only when no bus read is taking the data.
// - sampling switch closes only for a twelve-cycle window at conversion start.
// - reset clears the flag and all other control bits.
// - with bus clock, first result stored 23 cycles after the control write.
// - with alternate clock, a sync delay precedes each result update.
module adc_sequence_control #(
  parameter WIDTH = 8                       // result width
) (
  input  wire             CLK_I,            // 25 mhz clock
  input  wire             ARST_N_I,         // async reset, active low
  input  wire             CYC_I,            // wishbone cycle
  input  wire             STB_I,            // wishbone strobe
  input  wire             WE_I,             // wishbone write enable
  input  wire [15:0]      ADR_I,            // wishbone byte address
  input  wire [3:0]       SEL_I,            // wishbone byte selects
  input  wire [31:0]      DAT_I,            // wishbone write data
  output reg  [31:0]      DAT_O,            // wishbone read data
  output reg              ACK_O,            // wishbone acknowledge
  output reg              ERR_O,            // wishbone error, unmapped
  input  wire             CMP_I,            // comparator output
  output wire [3:0]       MUX_SEL_O,        // analog mux channel code
  output wire             MUX_PIN_O,        // a pin input is selected
  output wire             REF_HIGH_O,       // sample high reference
  output wire             REF_LOW_O,        // sample low reference
  output wire             REF_HALF_O,       // half-reference capacitor split
  output wire             SAMPLE_O,         // sampling switch closed
  output wire [WIDTH-1:0] DAC_O,            // dac trial code
  output wire             BUSY_O            // conversion sequence running
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [5:0]       ctl_r;                    // scan, group_channel_mode, channel select
  reg             ccf_r;
  reg             clock_source_select_r;
  reg             run_r;
  reg [1:0]       slot_r;                   // result slot being converted
  reg [2:0]       filled_r;                 // results stored since the control write, held at 4
  reg             start_r;
  reg             pend_r;                   // result waiting for store
  reg [2:0]       sync_r;
  reg [WIDTH-1:0] res_r [0:3];

  wire [3:0]       chan;
  wire             conv_done;
  wire [WIDTH-1:0] conv_res;
  wire             req;
  wire             wr;
  wire             rd;
  wire             ctl_hit;
  wire             opt_hit;
  wire             res_hit;
  wire [1:0]       res_idx;
  wire             store;
  wire             scan;
  wire             group_channel_mode;

  assign req     = CYC_I & STB_I & ~ACK_O & ~ERR_O;
  assign wr      = req & WE_I & SEL_I[0];
  assign rd      = req & ~WE_I;
  assign ctl_hit = (ADR_I == `ADC_CTL_ADDR);
  assign opt_hit = (ADR_I == `ADC_OPT_ADDR);
  assign res_hit = (ADR_I >= `ADC_RES1_ADDR) && (ADR_I <= `ADC_RES4_ADDR);
  assign res_idx = ADR_I[1:0] - 2'h1;
  assign scan    = ctl_r[`CTL_SCAN_BIT];
  assign group_channel_mode    = ctl_r[`CTL_GROUP_CHANNEL_MODE_BIT];

  // ------------------------------------------------------------
  // channel selection
  // ------------------------------------------------------------
  // group mode: upper select bits plus slot; low bits ignored
  assign chan       = group_channel_mode ? {ctl_r[3:2], slot_r} : ctl_r[3:0];
  assign MUX_SEL_O  = chan;
  assign MUX_PIN_O  = run_r & ~chan[3];
  assign REF_HIGH_O = run_r & (chan == `CHAN_VH);
  assign REF_LOW_O  = run_r & (chan == `CHAN_VL);
  assign REF_HALF_O = run_r & (chan == `CHAN_HALF) & SAMPLE_O;
  assign BUSY_O     = run_r;

  // ------------------------------------------------------------
  // converter core
  // ------------------------------------------------------------
  adc_sar_step #(
    .WIDTH (WIDTH)
  ) u_sar (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .start_i  (start_r),
    .abort_i  (wr & ctl_hit),
    .cmp_i    (CMP_I),
    .sample_o (SAMPLE_O),
    .trial_o  (DAC_O),
    .done_o   (conv_done),
    .result_o (conv_res)
  );

  // store is held off while a bus read is being answered
  assign store = pend_r & (sync_r == 3'h0) & ~rd;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ctl_r    <= `CTL_RESET;
      ccf_r    <= 1'b0;
      clock_source_select_r   <= `OPT_RESET;
      run_r    <= 1'b0;
      slot_r   <= 2'h0;
      filled_r <= 3'h0;
      start_r  <= 1'b0;
      pend_r   <= 1'b0;
      sync_r   <= 3'h0;
    end
    else
    begin
      start_r <= 1'b0;
      if (wr & opt_hit)
      begin
        clock_source_select_r <= DAT_I[`OPT_CLOCK_SOURCE_SELECT_BIT];
      end
      if (wr & ctl_hit)
      begin
        // bit 7 and bit 6 are not stored
        ctl_r    <= DAT_I[5:0];
        ccf_r    <= 1'b0;
        run_r    <= 1'b1;
        slot_r   <= 2'h0;
        filled_r <= 3'h0;
        start_r  <= 1'b1;
        pend_r   <= 1'b0;
        sync_r   <= 3'h0;
      end
      else
      begin
        if (conv_done)
        begin
          pend_r <= 1'b1;
          sync_r <= clock_source_select_r ? `SYNC_CYCLES : 3'h0;
        end
        else if (sync_r != 3'h0)
        begin
          sync_r <= sync_r - 3'h1;
        end
        if (store)
        begin
          pend_r <= 1'b0;
          slot_r <= slot_r + 2'h1;
          if (filled_r != 3'h4)
          begin
            filled_r <= filled_r + 3'h1;
          end
          // fourth result of this pass is in; later passes leave the flag set
          if (filled_r == 3'h3)
          begin
            ccf_r <= 1'b1;
          end
          if (slot_r == 2'h3)
          begin
            run_r <= scan;
            start_r <= scan;
          end
          else
          begin
            start_r <= 1'b1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // result registers
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_res
      always @(posedge CLK_I or negedge ARST_N_I)
      begin
        if (!ARST_N_I)
        begin
          res_r[gi] <= {WIDTH{1'b0}};
        end
        else if (store && (slot_r == gi))
        begin
          res_r[gi] <= conv_res;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  always @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      DAT_O <= 32'h0000_0000;
      ACK_O <= 1'b0;
      ERR_O <= 1'b0;
    end
    else
    begin
      ACK_O <= 1'b0;
      ERR_O <= 1'b0;
      if (req)
      begin
        if (ctl_hit | opt_hit | res_hit)
        begin
          ACK_O <= 1'b1;
        end
        else
        begin
          ERR_O <= 1'b1;
        end
        DAT_O <= 32'h0000_0000;
        if (!WE_I)
        begin
          if (ctl_hit)
          begin
            DAT_O[7:0] <= {ccf_r, 1'b0, ctl_r};
          end
          else if (opt_hit)
          begin
            DAT_O[`OPT_CLOCK_SOURCE_SELECT_BIT] <= clock_source_select_r;
          end
          else if (res_hit)
          begin
            DAT_O[WIDTH-1:0] <= res_r[res_idx];
          end
        end
      end
    end
  end

endmodule // adc_sequence_control
`default_nettype wire

// ### test/adc_seq_monitor.sv
// assertion checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module adc_seq_monitor #(
  parameter WIDTH = 8
) (
  input wire logic CLK_I, ARST_N_I, CYC_I, STB_I, WE_I,
  input wire logic [15:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O, ERR_O, MUX_PIN_O, REF_HIGH_O, REF_LOW_O, REF_HALF_O, SAMPLE_O, BUSY_O,
  input wire logic [3:0] MUX_SEL_O,
  input wire logic [WIDTH-1:0] DAC_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // ----
  // helper: control write taken, length of the sample window
  // ----
  wire ctl_wr = CYC_I && STB_I && WE_I && SEL_I[0] && !ACK_O && !ERR_O && ADR_I == `ADC_CTL_ADDR;
  logic [4:0] samp_cnt;
  always @(posedge CLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
      samp_cnt <= 5'h00;
    else if (ctl_wr || !SAMPLE_O)
      samp_cnt <= 5'h00;
    else
      samp_cnt <= samp_cnt + 5'h01;
  // ----
  // properties
  // ----
  property p_ack_one; CYC_I && STB_I && !ACK_O && !ERR_O |=> ACK_O != ERR_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("request not answered once");
  property p_rsvd; ACK_O && !WE_I && ADR_I == `ADC_CTL_ADDR |-> !DAT_O[6] && DAT_O[31:8] == 24'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit 6 read nonzero");
  property p_start; ctl_wr |-> ##[1:3] SAMPLE_O; endproperty
  a_start: assert property (p_start) else $error("write did not start sampling");
  property p_samp_len; $fell(SAMPLE_O) && !$past(ctl_wr) |-> samp_cnt == 5'h0c; endproperty
  a_samp_len: assert property (p_samp_len) else $error("sample window not 12");
  property p_samp_max; SAMPLE_O |-> samp_cnt < 5'h0c; endproperty
  a_samp_max: assert property (p_samp_max) else $error("sample window too long");
  property p_msb; $fell(SAMPLE_O) && !$past(ctl_wr) |-> DAC_O == {1'b1, {(WIDTH-1){1'b0}}}; endproperty
  a_msb: assert property (p_msb) else $error("first trial not msb");
  property p_half; REF_HALF_O == (SAMPLE_O && MUX_SEL_O == `CHAN_HALF); endproperty
  a_half: assert property (p_half) else $error("half reference control wrong");
  property p_decode;
    BUSY_O |-> MUX_PIN_O == !MUX_SEL_O[3] && REF_HIGH_O == (MUX_SEL_O == `CHAN_VH)
      && REF_LOW_O == (MUX_SEL_O == `CHAN_VL);
  endproperty
  a_decode: assert property (p_decode) else $error("channel decode wrong");
  property p_samp_busy; SAMPLE_O |-> BUSY_O; endproperty
  a_samp_busy: assert property (p_samp_busy) else $error("sampling while idle");
endmodule // adc_seq_monitor
bind adc_sequence_control adc_seq_monitor #(.WIDTH(WIDTH)) u_mon (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .ERR_O(ERR_O), .MUX_PIN_O(MUX_PIN_O), .REF_HIGH_O(REF_HIGH_O), .REF_LOW_O(REF_LOW_O),
  .REF_HALF_O(REF_HALF_O), .SAMPLE_O(SAMPLE_O), .BUSY_O(BUSY_O), .MUX_SEL_O(MUX_SEL_O), .DAC_O(DAC_O));
`default_nettype wire

// ### test/adc_sequence_control_tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module adc_sequence_control_tb_top;
  logic CLK_I = 0, ARST_N_I = 0, CYC_I = 0, STB_I = 0, WE_I = 0;
  logic [15:0] ADR_I = 0;
  logic [3:0] SEL_I = 0;
  logic [31:0] DAT_I = 0;
  logic [7:0] bias = 0;
  int num_errors = 0, comparisons = 0;
  wire [31:0] DAT_O;
  wire [7:0] DAC_O;
  wire [3:0] MUX_SEL_O;
  wire ACK_O, ERR_O, MUX_PIN_O, REF_HIGH_O, REF_LOW_O, REF_HALF_O, SAMPLE_O, BUSY_O;
  // ----
  // analog side: references hold fixed levels; other channel levels follow bias
  // ----
  function automatic logic [7:0] lvl(input logic [3:0] ch, input logic [7:0] b);
    case (ch)
      `CHAN_VH: lvl = 8'hff;
      `CHAN_VL: lvl = 8'h00;
      `CHAN_HALF: lvl = 8'h80;
      default: lvl = {ch, 4'h5} ^ b;
    endcase
  endfunction
  wire CMP_I = lvl(MUX_SEL_O, bias) >= DAC_O;
  adc_sequence_control u_dut (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .ERR_O(ERR_O), .CMP_I(CMP_I), .MUX_SEL_O(MUX_SEL_O), .MUX_PIN_O(MUX_PIN_O), .REF_HIGH_O(REF_HIGH_O),
    .REF_LOW_O(REF_LOW_O), .REF_HALF_O(REF_HALF_O), .SAMPLE_O(SAMPLE_O), .DAC_O(DAC_O), .BUSY_O(BUSY_O));
  initial forever #20 CLK_I = ~CLK_I;
  // ----
  // tasks
  // ----
  task automatic close_out;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q,
                    output logic e);
    int n;
  begin
    @(posedge CLK_I);
    CYC_I <= 1;
    STB_I <= 1;
    WE_I <= w;
    ADR_I <= a;
    SEL_I <= 4'h1;
    DAT_I <= {24'h0, d};
    n = 0;
    @(posedge CLK_I);
    while (ACK_O !== 1'b1 && ERR_O !== 1'b1 && n < 20)
    begin
      @(posedge CLK_I);
      n++;
    end
    if (ACK_O !== 1'b1 && ERR_O !== 1'b1)
    begin
      num_errors++;
      close_out;
    end
    q = DAT_O[7:0];
    e = ERR_O;
    CYC_I <= 0;
    STB_I <= 0;
    WE_I <= 0;
  end
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    logic e;
    wb(0, a, 8'h00, q, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    wb(1, a, d, q, e);
  endtask
  task automatic wait_ccf;
    logic [7:0] q;
    int n;
  begin
    q = 0;
    for (n = 0; n < 300 && q[7] !== 1'b1; n++)
      rd(`ADC_CTL_ADDR, q);
    if (q[7] !== 1'b1)
    begin
      num_errors++;
      close_out;
    end
  end
  endtask
  // waits until a sample window has just closed, so a write lands among the bit trials
  task automatic sync_trial;
    int n;
  begin
    for (n = 0; n < 200 && SAMPLE_O !== 1'b1; n++)
      @(posedge CLK_I);
    for (n = n; n < 200 && SAMPLE_O !== 1'b0; n++)
      @(posedge CLK_I);
    if (n >= 200)
    begin
      num_errors++;
      close_out;
    end
  end
  endtask
  // counts the idle cycles between one sample window and the next
  task automatic gap(output int g);
  begin
    sync_trial;
    for (g = 0; g < 200 && SAMPLE_O !== 1'b1; g++)
      @(posedge CLK_I);
    if (g >= 200)
    begin
      num_errors++;
      close_out;
    end
  end
  endtask
  task automatic chk_res(input logic [7:0] e0, e1, e2, e3, input logic [3:0] m);
    logic [7:0] q;
    logic [7:0] e [4];
  begin
    e = '{e0, e1, e2, e3};
    for (int i = 0; i < 4; i++)
    begin
      rd(`ADC_RES1_ADDR + 16'(i), q);
      if (m[i]) `CHK("result", e[i], q)
    end
  end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_single;
    logic [7:0] q;
    logic e;
    logic seen;
  begin
    rd(`ADC_CTL_ADDR, q);
    `CHK("ctl reset", 8'h00, q)
    wr(`ADC_CTL_ADDR, 8'hc3);
    rd(`ADC_CTL_ADDR, q);
    `CHK("ctl write", 8'h03, q)
    wb(0, 16'h1035, 8'h00, q, e);
    `CHK("unmapped", 1'b1, e)
    wait_ccf;
    wr(`ADC_RES1_ADDR, 8'h5a);
    chk_res(lvl(3, 0), lvl(3, 0), lvl(3, 0), lvl(3, 0), 4'hf);
    seen = 0;
    repeat (60) @(posedge CLK_I) seen |= (SAMPLE_O !== 1'b0);
    `CHK("stopped", 1'b0, seen)
    wr(`ADC_CTL_ADDR, 8'h05);
    // the read below latches the first result 34 cycles after the write edge
    repeat (31) @(posedge CLK_I);
    rd(`ADC_RES1_ADDR, q);
    `CHK("first slot", lvl(5, 0), q)
    $display("t_single done");
  end
  endtask
  task automatic t_group;
  begin
    for (int g = 0; g < 4; g++)
    begin
      wr(`ADC_CTL_ADDR, 8'h12 | 8'(g << 2));
      wait_ccf;
      chk_res(lvl(4*g, 0), lvl(4*g+1, 0), lvl(4*g+2, 0), lvl(4*g+3, 0), g == 3 ? 4'h7 : 4'hf);
    end
    $display("t_group done");
  end
  endtask
  task automatic t_scan;
    logic [7:0] q;
  begin
    wr(`ADC_CTL_ADDR, 8'h21);
    wait_ccf;
    bias <= 8'h3c;
    repeat (200) @(posedge CLK_I);
    rd(`ADC_CTL_ADDR, q);
    `CHK("flag kept", 8'ha1, q)
    `CHK("running", 1'b1, BUSY_O)
    chk_res(lvl(1, 8'h3c), lvl(1, 8'h3c), lvl(1, 8'h3c), lvl(1, 8'h3c), 4'hf);
    sync_trial;
    wr(`ADC_CTL_ADDR, 8'h02);
    rd(`ADC_CTL_ADDR, q);
    `CHK("flag cleared", 8'h02, q)
    sync_trial;
    wr(`ADC_CTL_ADDR, 8'h46);
    wait_ccf;
    chk_res(lvl(6, 8'h3c), lvl(6, 8'h3c), lvl(6, 8'h3c), lvl(6, 8'h3c), 4'hf);
    rd(`ADC_CTL_ADDR, q);
    `CHK("complete", 8'h86, q)
    $display("t_scan done");
  end
  endtask
  task automatic t_clock_source_select;
    logic [7:0] q;
    int g0;
    int g1;
  begin
    wr(`ADC_CTL_ADDR, 8'h0c);
    gap(g0);
    wait_ccf;
    wr(`ADC_OPT_ADDR, 8'h40);
    wr(`ADC_CTL_ADDR, 8'h0c);
    gap(g1);
    wait_ccf;
    `CHK("sync delay", int'(`SYNC_CYCLES), g1 - g0)
    chk_res(8'hff, 8'hff, 8'hff, 8'hff, 4'hf);
    wr(`ADC_OPT_ADDR, 8'h00);
    ARST_N_I <= 0;
    repeat (2) @(posedge CLK_I);
    ARST_N_I <= 1;
    rd(`ADC_CTL_ADDR, q);
    `CHK("flag reset", 1'b0, q[7])
    $display("t_clock_source_select done");
  end
  endtask
  initial
  begin
    repeat (5) @(posedge CLK_I);
    ARST_N_I <= 1;
    t_single;
    t_group;
    t_scan;
    t_clock_source_select;
    close_out;
  end
endmodule // adc_sequence_control_tb_top
`default_nettype wire
